// ===== hdl/imd_defs.svh
/*
  Constants of the integer execution datapath with its multiply/divide unit:
  widths, register-file size and the cycle counts of the multiply/divide unit.
  Assumes one pipeline clock; every count below is in pipeline clock cycles.
*/
`ifndef IMD_DEFS_SVH
`define IMD_DEFS_SVH

`define IMD_XLEN 64
`define IMD_NREG 32
`define IMD_SHORT_MSB 15

// latency and repeat of word product and accumulate
`define IMD_LAT_W16 7'h03
`define IMD_REP_W16 7'h02
`define IMD_LAT_W32 7'h04
`define IMD_REP_W32 7'h03
// pipeline stall cycles of the direct product
`define IMD_STALL_W16 2'h1
`define IMD_STALL_W32 2'h2
// doubleword product, word and doubleword quotient
`define IMD_LAT_DWMUL 7'h06
`define IMD_REP_DWMUL 7'h05
`define IMD_LAT_WDIV 7'h24
`define IMD_REP_WDIV 7'h24
`define IMD_LAT_DWDIV 7'h44
`define IMD_REP_DWDIV 7'h44

`endif

// ===== hdl/imd_pkg.sv
/*
  Types shared by the integer datapath files: the operation code set.
  Assumes the issuing pipeline decodes instructions into these codes.
*/
package imd_pkg;

  typedef enum logic [4:0] {
    IMD_OP_NOP,
    IMD_OP_ADD,
    IMD_OP_SUB,
    IMD_OP_AND,
    IMD_OP_OR,
    IMD_OP_XOR,
    IMD_OP_NOR,
    IMD_OP_SLL,
    IMD_OP_SRL,
    IMD_OP_SRA,
    IMD_OP_LOAD,
    IMD_OP_STORE,
    IMD_OP_SIGNED_UNSIGNED_PRODUCT,
    IMD_OP_PRODUCT_ACCUMULATE,
    IMD_OP_DIRECT_PRODUCT,
    IMD_OP_DOUBLEWORD_PRODUCT,
    IMD_OP_WORD_QUOTIENT,
    IMD_OP_DOUBLEWORD_QUOTIENT,
    IMD_OP_RESULT_MOVE_UPPER,
    IMD_OP_RESULT_MOVE_BOTTOM
  } imd_op_t;

endpackage

// ===== hdl/imd_regfile.sv
/*
  General register file: two read ports with registered read data, one write port.
  Assumes write and reads on the same clock; a same-cycle write is seen by the read.
*/
module imd_regfile #(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned WIDTH = 64,
  parameter int unsigned AW = $clog2(DEPTH)
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [AW-1:0] ra_a_i,
  input wire logic [AW-1:0] ra_b_i,
  output logic [WIDTH-1:0] rdata_a_o,
  output logic [WIDTH-1:0] rdata_b_o,
  input wire logic we_i,
  input wire logic [AW-1:0] wa_i,
  input wire logic [WIDTH-1:0] wd_i
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rd_a;
    logic [WIDTH-1:0] rd_b;
  } imd_rf_state_t;

  imd_rf_state_t q;
  imd_rf_state_t d;

  always_comb begin
    d = q;
    if (we_i) begin
      d.mem[wa_i] = wd_i;
    end
    // write-first keeps the oldest in-flight result out of the bypass net
    d.rd_a = (we_i && wa_i == ra_a_i) ? wd_i : q.mem[ra_a_i];
    d.rd_b = (we_i && wa_i == ra_b_i) ? wd_i : q.mem[ra_b_i];
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata_a_o = q.rd_a;
  assign rdata_b_o = q.rd_b;

endmodule // imd_regfile

// ===== hdl/imd_core.sv
/*
  Integer execution datapath: issue (ID), execute, memory and write-back stages,
  single-cycle adder and logic/shift unit, and the pipelined multiply/divide unit
  with its upper and bottom result registers.
  Assumes the instruction fetch stage and decoding sit outside and drive the issue
  port on the same clock; data memory answers a request in the request cycle.
*/
`include "imd_defs.svh"

module imd_core (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic issue_valid_i,
  input wire imd_pkg::imd_op_t issue_op_i,
  input wire logic issue_unsigned_i,
  input wire logic issue_use_imm_i,
  input wire logic [15:0] issue_imm_i,
  input wire logic [4:0] issue_rs_i,
  input wire logic [4:0] issue_rt_i,
  input wire logic [4:0] issue_rd_i,
  output logic issue_ready_o,
  output logic dmem_req_o,
  output logic dmem_we_o,
  output logic [`IMD_XLEN-1:0] dmem_addr_o,
  output logic [`IMD_XLEN-1:0] dmem_wdata_o,
  input wire logic [`IMD_XLEN-1:0] dmem_rdata_i,
  output logic wb_valid_o,
  output logic [4:0] wb_dst_o,
  output logic [`IMD_XLEN-1:0] wb_data_o
);

  typedef struct packed {
    logic ready;
    logic ex_valid;
    imd_pkg::imd_op_t ex_op;
    logic ex_uns;
    logic ex_imm_en;
    logic [15:0] ex_imm;
    logic [4:0] ex_rs;
    logic [4:0] ex_rt;
    logic [4:0] ex_rd;
    logic mem_wr;
    logic mem_load;
    logic [4:0] mem_dst;
    logic [63:0] mem_res;
    logic dreq;
    logic dwe;
    logic [63:0] daddr;
    logic [63:0] dwdata;
    logic wb_valid;
    logic [4:0] wb_dst;
    logic [63:0] wb_data;
    logic [63:0] hi;
    logic [63:0] lo;
    logic [6:0] rep;
    logic [6:0] lat;
    logic mul_run;
    logic [1:0] mul_left;
  } imd_core_state_t;

  imd_core_state_t q;
  imd_core_state_t d;

  logic accept;
  logic [4:0] ra_a;
  logic [4:0] ra_b;
  logic [63:0] rf_a;
  logic [63:0] rf_b;
  logic [63:0] mem_val;
  logic [63:0] opa;
  logic [63:0] opb;
  logic [63:0] imm_ext;
  logic [63:0] b_val;
  logic [63:0] sum;
  logic [63:0] alu;
  logic [63:0] hi_new;
  logic [63:0] lo_new;
  logic [63:0] acc;
  logic [6:0] lat_sel;
  logic [6:0] rep_sel;
  logic [1:0] stall_sel;
  logic short_ops;
  logic start;
  logic hold_now;
  logic adv;
  logic signed [32:0] wa33;
  logic signed [32:0] wb33;
  logic signed [65:0] pw;
  logic signed [64:0] da65;
  logic signed [64:0] db65;
  logic signed [129:0] pd;
  logic signed [32:0] wq;
  logic signed [32:0] wr;
  logic signed [64:0] dq;
  logic signed [64:0] dr;

  function automatic logic [63:0] sx32(input logic [31:0] v);
    sx32 = {{32{v[31]}}, v};
  endfunction

  function automatic logic is16(input logic [63:0] v);
    is16 = (v[63:`IMD_SHORT_MSB] == '0) || (v[63:`IMD_SHORT_MSB] == '1);
  endfunction

  function automatic logic is_md(input imd_pkg::imd_op_t op);
    is_md = op inside {imd_pkg::IMD_OP_SIGNED_UNSIGNED_PRODUCT,
                       imd_pkg::IMD_OP_PRODUCT_ACCUMULATE,
                       imd_pkg::IMD_OP_DIRECT_PRODUCT,
                       imd_pkg::IMD_OP_DOUBLEWORD_PRODUCT,
                       imd_pkg::IMD_OP_WORD_QUOTIENT,
                       imd_pkg::IMD_OP_DOUBLEWORD_QUOTIENT};
  endfunction

  function automatic logic writes_reg(input imd_pkg::imd_op_t op);
    writes_reg = op inside {[imd_pkg::IMD_OP_ADD : imd_pkg::IMD_OP_LOAD],
                            imd_pkg::IMD_OP_DIRECT_PRODUCT,
                            imd_pkg::IMD_OP_RESULT_MOVE_UPPER,
                            imd_pkg::IMD_OP_RESULT_MOVE_BOTTOM};
  endfunction

  // interlock decision, also used to predict the next cycle
  function automatic logic hold_f(input logic v, input imd_pkg::imd_op_t op,
                                  input logic [6:0] rep, input logic [6:0] lat,
                                  input logic run, input logic [1:0] left);
    hold_f = 1'b0;
    if (v) begin
      if (op == imd_pkg::IMD_OP_DIRECT_PRODUCT) begin
        hold_f = !run || (left != 2'h0);
      end else if (is_md(op)) begin
        hold_f = (rep != 7'h00);
      end else if (op inside {imd_pkg::IMD_OP_RESULT_MOVE_UPPER,
                              imd_pkg::IMD_OP_RESULT_MOVE_BOTTOM}) begin
        hold_f = (lat != 7'h00);
      end
    end
  endfunction

  // bypass from memory and write-back stages
  function automatic logic [63:0] fwd(input logic [4:0] r, input logic [63:0] rf,
                                      input logic mw, input logic [4:0] md,
                                      input logic [63:0] mv, input logic ww,
                                      input logic [4:0] wd, input logic [63:0] wv);
    if (mw && md == r) begin
      fwd = mv;
    end else if (ww && wd == r) begin
      fwd = wv;
    end else begin
      fwd = rf;
    end
  endfunction

  assign accept = issue_valid_i && q.ready;
  // held operations re-read their sources so late writes are picked up
  assign ra_a = accept ? issue_rs_i : q.ex_rs;
  assign ra_b = accept ? issue_rt_i : q.ex_rt;
  assign mem_val = q.mem_load ? dmem_rdata_i : q.mem_res;
  assign opa = fwd(q.ex_rs, rf_a, q.mem_wr, q.mem_dst, mem_val, q.wb_valid, q.wb_dst,
                   q.wb_data);
  assign opb = fwd(q.ex_rt, rf_b, q.mem_wr, q.mem_dst, mem_val, q.wb_valid, q.wb_dst,
                   q.wb_data);

  imd_regfile #(
    .DEPTH(`IMD_NREG),
    .WIDTH(`IMD_XLEN)
  ) u_regfile (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ra_a_i(ra_a),
    .ra_b_i(ra_b),
    .rdata_a_o(rf_a),
    .rdata_b_o(rf_b),
    .we_i(q.wb_valid),
    .wa_i(q.wb_dst),
    .wd_i(q.wb_data)
  );

  always_comb begin
    d = q;
    imm_ext = {{48{q.ex_imm[15]}}, q.ex_imm};
    // adder shared by arithmetic and address calculation
    b_val = (q.ex_imm_en || q.ex_op inside {imd_pkg::IMD_OP_LOAD, imd_pkg::IMD_OP_STORE})
            ? imm_ext : opb;
    sum = opa + b_val;
    // size detected from the operand values
    short_ops = is16(opa) && is16(opb);
    wa33 = {~q.ex_uns & opa[31], opa[31:0]};
    wb33 = {~q.ex_uns & opb[31], opb[31:0]};
    pw = wa33 * wb33;
    da65 = {~q.ex_uns & opa[63], opa};
    db65 = {~q.ex_uns & opb[63], opb};
    pd = da65 * db65;
    // a zero divisor gives an all-ones quotient and the dividend as remainder
    wq = '1;
    wr = wa33;
    if (opb[31:0] != 32'h0) begin
      wq = wa33 / wb33;
      wr = wa33 % wb33;
    end
    dq = '1;
    dr = da65;
    if (opb != 64'h0) begin
      dq = da65 / db65;
      dr = da65 % db65;
    end
    // product added to the joined upper:bottom pair
    acc = {q.hi[31:0], q.lo[31:0]} + pw[63:0];
    // one-cycle logical, shift, add and subtract
    unique case (q.ex_op)
      imd_pkg::IMD_OP_ADD: alu = sum;
      imd_pkg::IMD_OP_SUB: alu = opa - b_val;
      imd_pkg::IMD_OP_AND: alu = opa & b_val;
      imd_pkg::IMD_OP_OR: alu = opa | b_val;
      imd_pkg::IMD_OP_XOR: alu = opa ^ b_val;
      imd_pkg::IMD_OP_NOR: alu = ~(opa | b_val);
      imd_pkg::IMD_OP_SLL: alu = opa << b_val[5:0];
      imd_pkg::IMD_OP_SRL: alu = opa >> b_val[5:0];
      imd_pkg::IMD_OP_SRA: alu = $unsigned($signed(opa) >>> b_val[5:0]);
      // direct product straight to a general register
      imd_pkg::IMD_OP_DIRECT_PRODUCT: alu = sx32(pw[31:0]);
      imd_pkg::IMD_OP_RESULT_MOVE_UPPER: alu = q.hi;
      imd_pkg::IMD_OP_RESULT_MOVE_BOTTOM: alu = q.lo;
      default: alu = 64'h0;
    endcase
    lat_sel = short_ops ? `IMD_LAT_W16 : `IMD_LAT_W32;
    rep_sel = short_ops ? `IMD_REP_W16 : `IMD_REP_W32;
    stall_sel = short_ops ? `IMD_STALL_W16 : `IMD_STALL_W32;
    hi_new = sx32(pw[63:32]);
    lo_new = sx32(pw[31:0]);
    case (q.ex_op)
      imd_pkg::IMD_OP_PRODUCT_ACCUMULATE: begin
        hi_new = sx32(acc[63:32]);
        lo_new = sx32(acc[31:0]);
      end
      imd_pkg::IMD_OP_DOUBLEWORD_PRODUCT: begin
        lat_sel = `IMD_LAT_DWMUL;
        rep_sel = `IMD_REP_DWMUL;
        hi_new = pd[127:64];
        lo_new = pd[63:0];
      end
      imd_pkg::IMD_OP_WORD_QUOTIENT: begin
        lat_sel = `IMD_LAT_WDIV;
        rep_sel = `IMD_REP_WDIV;
        hi_new = sx32(wr[31:0]);
        lo_new = sx32(wq[31:0]);
      end
      imd_pkg::IMD_OP_DOUBLEWORD_QUOTIENT: begin
        lat_sel = `IMD_LAT_DWDIV;
        rep_sel = `IMD_REP_DWDIV;
        hi_new = dr[63:0];
        lo_new = dq[63:0];
      end
      default: begin
      end
    endcase
    // repeat and latency counters run down every cycle
    d.rep = (q.rep != 7'h00) ? q.rep - 7'h01 : q.rep;
    d.lat = (q.lat != 7'h00) ? q.lat - 7'h01 : q.lat;
    start = q.ex_valid && is_md(q.ex_op) && !q.mul_run && (q.rep == 7'h00);
    if (start) begin
      d.rep = rep_sel - 7'h01;
      if (q.ex_op == imd_pkg::IMD_OP_DIRECT_PRODUCT) begin
        d.mul_run = 1'b1;
        d.mul_left = stall_sel - 2'h1;
      end else begin
        // results land in upper and bottom registers
        // results are committed at start; the latency counter guards reads
        d.lat = lat_sel - 7'h01;
        d.hi = hi_new;
        d.lo = lo_new;
      end
    end else if (q.mul_run) begin
      if (q.mul_left != 2'h0) begin
        d.mul_left = q.mul_left - 2'h1;
      end else begin
        d.mul_run = 1'b0;
      end
    end
    // hold the operation in execute until its unit is ready
    hold_now = hold_f(q.ex_valid, q.ex_op, q.rep, q.lat, q.mul_run, q.mul_left);
    adv = q.ex_valid && !hold_now;
    // execute to memory stage; a held slot sends a bubble
    d.mem_wr = adv && writes_reg(q.ex_op) && (q.ex_rd != 5'h00);
    d.mem_load = adv && (q.ex_op == imd_pkg::IMD_OP_LOAD);
    d.mem_dst = q.ex_rd;
    d.mem_res = alu;
    // memory touched only by load and store
    d.dreq = adv && (q.ex_op inside {imd_pkg::IMD_OP_LOAD, imd_pkg::IMD_OP_STORE});
    d.dwe = adv && (q.ex_op == imd_pkg::IMD_OP_STORE);
    d.daddr = sum;
    d.dwdata = opb;
    d.wb_valid = q.mem_wr;
    d.wb_dst = q.mem_dst;
    d.wb_data = mem_val;
    if (accept) begin
      d.ex_valid = 1'b1;
      d.ex_op = issue_op_i;
      d.ex_uns = issue_unsigned_i;
      d.ex_imm_en = issue_use_imm_i;
      d.ex_imm = issue_imm_i;
      d.ex_rs = issue_rs_i;
      d.ex_rt = issue_rt_i;
      d.ex_rd = issue_rd_i;
    end else if (!hold_now) begin
      d.ex_valid = 1'b0;
    end
    // ready predicts next cycle's interlock exactly
    d.ready = !hold_f(d.ex_valid, d.ex_op, d.rep, d.lat, d.mul_run, d.mul_left);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign issue_ready_o = q.ready;
  assign dmem_req_o = q.dreq;
  assign dmem_we_o = q.dwe;
  assign dmem_addr_o = q.daddr;
  assign dmem_wdata_o = q.dwdata;
  assign wb_valid_o = q.wb_valid;
  assign wb_dst_o = q.wb_dst;
  assign wb_data_o = q.wb_data;

endmodule // imd_core

// ===== verification/imd_core_checker.sv
/*
  Concurrent checks on the ports of imd_core, bound into every instance.
  Assumes the single pipeline clock clk_i and the async low reset rst_n_i.
*/
`include "imd_defs.svh"

module imd_core_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic issue_valid_i,
  input wire imd_pkg::imd_op_t issue_op_i,
  input wire logic issue_unsigned_i,
  input wire logic issue_use_imm_i,
  input wire logic [15:0] issue_imm_i,
  input wire logic [4:0] issue_rs_i,
  input wire logic [4:0] issue_rt_i,
  input wire logic [4:0] issue_rd_i,
  input wire logic issue_ready_o,
  input wire logic dmem_req_o,
  input wire logic dmem_we_o,
  input wire logic [`IMD_XLEN-1:0] dmem_addr_o,
  input wire logic [`IMD_XLEN-1:0] dmem_wdata_o,
  input wire logic [`IMD_XLEN-1:0] dmem_rdata_i,
  input wire logic wb_valid_o,
  input wire logic [4:0] wb_dst_o,
  input wire logic [`IMD_XLEN-1:0] wb_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic taken;
  logic ldst;
  logic [6:0] gap_q;
  assign taken = issue_valid_i && issue_ready_o;
  assign ldst = issue_op_i inside {imd_pkg::IMD_OP_LOAD, imd_pkg::IMD_OP_STORE};
  // cycles since the last multiply/divide or move was taken; a long gap means
  // nothing can still hold the execute stage, so stall counts are exact.
  // reset leaves no unit busy, so it starts saturated
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) gap_q <= 7'h7f;
    else if (taken && issue_op_i >= imd_pkg::IMD_OP_SIGNED_UNSIGNED_PRODUCT) gap_q <= 7'h0;
    else if (gap_q != 7'h7f) gap_q <= gap_q + 7'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_ready_after_reset;
    $rose(rst_n_i) |-> !issue_ready_o ##1 issue_ready_o;
  endproperty
  a_ready_after_reset: assert property (p_ready_after_reset) else $error("ready timing after reset");
  property p_alu_wb;
    taken && issue_op_i inside {[imd_pkg::IMD_OP_ADD:imd_pkg::IMD_OP_SRA]} && issue_rd_i != 5'h0
      |-> ##3 wb_valid_o && wb_dst_o == $past(issue_rd_i, 3);
  endproperty
  a_alu_wb: assert property (p_alu_wb) else $error("alu result not written after three cycles");
  property p_load_req;
    taken && issue_op_i == imd_pkg::IMD_OP_LOAD |-> ##2 dmem_req_o && !dmem_we_o;
  endproperty
  a_load_req: assert property (p_load_req) else $error("load request missing");
  property p_store_req;
    taken && issue_op_i == imd_pkg::IMD_OP_STORE |-> ##2 dmem_req_o && dmem_we_o;
  endproperty
  a_store_req: assert property (p_store_req) else $error("store request missing");
  property p_req_cause;
    dmem_req_o |-> $past(taken && ldst, 2);
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("memory request without load or store");
  property p_load_data;
    taken && issue_op_i == imd_pkg::IMD_OP_LOAD && issue_rd_i != 5'h0
      |-> ##2 dmem_req_o ##1 wb_valid_o && wb_data_o == $past(dmem_rdata_i);
  endproperty
  a_load_data: assert property (p_load_data) else $error("load data not written back");
  property p_no_zero_dst;
    wb_valid_o |-> wb_dst_o != 5'h0;
  endproperty
  a_no_zero_dst: assert property (p_no_zero_dst) else $error("write to register zero");
  property p_word_no_stall;
    taken && gap_q >= 7'h64 && issue_op_i inside {imd_pkg::IMD_OP_SIGNED_UNSIGNED_PRODUCT,
      imd_pkg::IMD_OP_PRODUCT_ACCUMULATE}
      |-> ##1 issue_ready_o ##1 (issue_ready_o || $past(taken));
  endproperty
  a_word_no_stall: assert property (p_word_no_stall) else $error("word product stalled");
  property p_direct_stall;
    taken && gap_q >= 7'h64 && issue_op_i == imd_pkg::IMD_OP_DIRECT_PRODUCT
      |-> ##1 !issue_ready_o ##[1:2] issue_ready_o;
  endproperty
  a_direct_stall: assert property (p_direct_stall) else $error("direct product stall count");
endmodule // imd_core_checker

bind imd_core imd_core_checker i_chk (.clk_i, .rst_n_i, .issue_valid_i, .issue_op_i,
  .issue_unsigned_i, .issue_use_imm_i, .issue_imm_i, .issue_rs_i, .issue_rt_i, .issue_rd_i,
  .issue_ready_o, .dmem_req_o, .dmem_we_o, .dmem_addr_o, .dmem_wdata_o, .dmem_rdata_i,
  .wb_valid_o, .wb_dst_o, .wb_data_o);

// ===== verification/imd_dmem_model.sv
/*
  Data memory model on the far side of the load/store port, 32 words of 64 bits.
  Assumes one-cycle requests whose read data is wanted in the request cycle.
*/
module imd_dmem_model (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [63:0] addr_i,
  input wire logic [63:0] wdata_i,
  output logic [63:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] mem_q [32];
  logic [63:0] last_q = 64'h0;
  always @(posedge clk_i) begin
    if (req_i && we_i) mem_q[addr_i[7:3]] <= wdata_i;
    if (req_i) last_q <= rdata_o;
  end
  // load answers same cycle; idle bus shows inverted data so stale reads fail
  always_comb begin
    if (req_i) rdata_o = mem_q[addr_i[7:3]];
    else rdata_o = ~last_q;
  end
endmodule // imd_dmem_model

// ===== verification/tb.sv
/*
  Self-checking bench of imd_core with a data memory model on its load/store port.
  Assumes the checker is bound from its own file.
*/
`include "imd_defs.svh"
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {imd_pkg::imd_op_t op; logic [4:0] rs, rt; logic uns; int lat;
    logic [63:0] up, lo;} imd_mcase_t;
  typedef struct {imd_pkg::imd_op_t op; logic [4:0] rs, rt, ds; int dly;
    logic [63:0] v;} imd_dcase_t;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic issue_valid_i = 1'b0;
  imd_pkg::imd_op_t issue_op_i = imd_pkg::IMD_OP_NOP;
  logic issue_unsigned_i = 1'b0;
  logic issue_use_imm_i = 1'b0;
  logic [15:0] issue_imm_i = 16'h0;
  logic [4:0] issue_rs_i = 5'h0;
  logic [4:0] issue_rt_i = 5'h0;
  logic [4:0] issue_rd_i = 5'h0;
  logic issue_ready_o, dmem_req_o, dmem_we_o, wb_valid_o;
  logic [4:0] wb_dst_o;
  logic [63:0] dmem_addr_o, dmem_wdata_o, dmem_rdata_i, wb_data_o;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  int t_take = 0;
  logic [63:0] wb_val [32];
  int wb_at [32];
  localparam logic [63:0] ALU_EXP [12] = '{64'h7, 64'hffff_ffff_ffff_fffd, 64'h70_0000,
    64'h7fff, 64'h8000, 64'ha, 64'h70_0000, 64'hffff_ffff_ffff_ffff, 64'hffff_ffff_ffff_fffa,
    64'h0, 64'hf, 64'hffff_ffff_ffff_fffe};
  imd_mcase_t mtab [10] = '{
    '{imd_pkg::IMD_OP_SIGNED_UNSIGNED_PRODUCT, 1, 2, 0, 3, '1, 64'hffff_ffff_ffff_ffeb},
    '{imd_pkg::IMD_OP_SIGNED_UNSIGNED_PRODUCT, 3, 2, 0, 4, '1, 64'hffff_ffff_feb0_0000},
    '{imd_pkg::IMD_OP_SIGNED_UNSIGNED_PRODUCT, 4, 1, 0, 3, 64'h0, 64'h3_7ff9},
    '{imd_pkg::IMD_OP_SIGNED_UNSIGNED_PRODUCT, 5, 1, 0, 4, 64'h0, 64'h3_8000},
    '{imd_pkg::IMD_OP_SIGNED_UNSIGNED_PRODUCT, 1, 1, 1, 3, 64'h0, 64'h31},
    '{imd_pkg::IMD_OP_PRODUCT_ACCUMULATE, 1, 1, 0, 3, 64'h0, 64'h62},
    '{imd_pkg::IMD_OP_DOUBLEWORD_PRODUCT, 3, 3, 0, 6, 64'h0, 64'h3100_0000_0000},
    '{imd_pkg::IMD_OP_WORD_QUOTIENT, 3, 1, 0, 36, 64'h0, 64'h10_0000},
    '{imd_pkg::IMD_OP_DOUBLEWORD_QUOTIENT, 3, 2, 0, 68, 64'h1, 64'hffff_ffff_ffda_aaab},
    '{imd_pkg::IMD_OP_WORD_QUOTIENT, 1, 0, 0, 36, 64'h7, '1}};
  imd_dcase_t dtab [5] = '{
    '{imd_pkg::IMD_OP_NOP, 0, 0, 1, 5, 64'hffff_ffff_ffff_ffeb},
    '{imd_pkg::IMD_OP_NOP, 0, 0, 3, 6, 64'hffff_ffff_feb0_0000},
    '{imd_pkg::IMD_OP_SIGNED_UNSIGNED_PRODUCT, 1, 2, 1, 6, 64'hffff_ffff_ffff_ffeb},
    '{imd_pkg::IMD_OP_DOUBLEWORD_PRODUCT, 3, 3, 1, 9, 64'hffff_ffff_ffff_ffeb},
    '{imd_pkg::IMD_OP_DOUBLEWORD_QUOTIENT, 3, 2, 1, 72, 64'hffff_ffff_ffff_ffeb}};

  imd_core i_dut (.clk_i, .rst_n_i, .issue_valid_i, .issue_op_i, .issue_unsigned_i,
    .issue_use_imm_i, .issue_imm_i, .issue_rs_i, .issue_rt_i, .issue_rd_i, .issue_ready_o,
    .dmem_req_o, .dmem_we_o, .dmem_addr_o, .dmem_wdata_o, .dmem_rdata_i, .wb_valid_o,
    .wb_dst_o, .wb_data_o);
  imd_dmem_model i_mem (.clk_i(clk_i), .req_i(dmem_req_o), .we_i(dmem_we_o),
    .addr_i(dmem_addr_o), .wdata_i(dmem_wdata_o), .rdata_o(dmem_rdata_i));

  always #12.5 clk_i = ~clk_i;
  // count cycles and log write-backs at mid-cycle, clear of the sampling edge
  always @(negedge clk_i) begin
    cyc++;
    if (wb_valid_o === 1'b1) begin
      wb_val[wb_dst_o] = wb_data_o;
      wb_at[wb_dst_o] = cyc;
    end
  end

  task automatic stop_test();
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // valid stays up between operations so it is never driven twice in one step
  task automatic issue(imd_pkg::imd_op_t op, logic [4:0] rd, rs, rt, logic im,
      logic [15:0] imm, logic uns);
    issue_valid_i = 1'b1;
    issue_op_i = op;
    issue_rd_i = rd;
    issue_rs_i = rs;
    issue_rt_i = rt;
    issue_use_imm_i = im;
    issue_imm_i = imm;
    issue_unsigned_i = uns;
    @(negedge clk_i);
    while (issue_ready_o !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
    t_take = cyc;
    #1;
  endtask

  task automatic settle(int k);
    issue_valid_i = 1'b0;
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task automatic t_alu();
    issue(imd_pkg::IMD_OP_ADD, 1, 0, 0, 1, 16'h0007, 0);
    issue(imd_pkg::IMD_OP_ADD, 2, 0, 0, 1, 16'hfffd, 0);
    issue(imd_pkg::IMD_OP_SLL, 3, 1, 0, 1, 16'h0014, 0);
    issue(imd_pkg::IMD_OP_ADD, 4, 0, 0, 1, 16'h7fff, 0);
    issue(imd_pkg::IMD_OP_ADD, 5, 4, 0, 1, 16'h0001, 0);
    issue(imd_pkg::IMD_OP_SUB, 6, 1, 2, 0, 16'h0, 0);
    issue(imd_pkg::IMD_OP_AND, 7, 3, 2, 0, 16'h0, 0);
    issue(imd_pkg::IMD_OP_OR, 8, 1, 2, 0, 16'h0, 0);
    issue(imd_pkg::IMD_OP_XOR, 9, 1, 2, 0, 16'h0, 0);
    issue(imd_pkg::IMD_OP_NOR, 10, 1, 2, 0, 16'h0, 0);
    issue(imd_pkg::IMD_OP_SRL, 11, 2, 0, 1, 16'h003c, 0);
    issue(imd_pkg::IMD_OP_SRA, 12, 2, 0, 1, 16'h0001, 0);
    settle(6);
    for (int i = 0; i < 12; i++) `CHK("alu result", ALU_EXP[i], wb_val[i + 1])
    `CHK("alu cycle", t_take + 3, wb_at[12])
  endtask

  task automatic t_mem();
    issue(imd_pkg::IMD_OP_STORE, 0, 0, 3, 1, 16'h0040, 0);
    issue(imd_pkg::IMD_OP_LOAD, 13, 0, 0, 1, 16'h0040, 0);
    issue(imd_pkg::IMD_OP_ADD, 14, 13, 0, 1, 16'h0001, 0);
    settle(6);
    `CHK("load", 64'h70_0000, wb_val[13])
    `CHK("load use", 64'h70_0001, wb_val[14])
  endtask

  task automatic t_mdu();
    int t0;
    foreach (mtab[i]) begin
      issue(mtab[i].op, 0, mtab[i].rs, mtab[i].rt, 0, 16'h0, mtab[i].uns);
      t0 = t_take;
      issue(imd_pkg::IMD_OP_RESULT_MOVE_UPPER, 20, 0, 0, 0, 16'h0, 0);
      issue(imd_pkg::IMD_OP_RESULT_MOVE_BOTTOM, 21, 0, 0, 0, 16'h0, 0);
      settle(8);
      `CHK("upper", mtab[i].up, wb_val[20])
      `CHK("bottom", mtab[i].lo, wb_val[21])
      `CHK("move cycle", t0 + mtab[i].lat + 3, wb_at[20])
    end
  endtask

  task automatic t_direct();
    int t0;
    // a long idle gap first, so the checker's stall count applies to the first direct product
    settle(100);
    foreach (dtab[i]) begin
      issue(dtab[i].op, 0, dtab[i].rs, dtab[i].rt, 0, 16'h0, 0);
      t0 = t_take;
      issue(imd_pkg::IMD_OP_DIRECT_PRODUCT, 22, dtab[i].ds, 2, 0, 16'h0, 0);
      settle(dtab[i].dly + 4);
      `CHK("direct", dtab[i].v, wb_val[22])
      `CHK("direct cycle", t0 + dtab[i].dly, wb_at[22])
    end
    issue(imd_pkg::IMD_OP_RESULT_MOVE_BOTTOM, 21, 0, 0, 0, 16'h0, 0);
    settle(6);
    `CHK("bottom kept", 64'hffff_ffff_ffda_aaab, wb_val[21])
  endtask

  task automatic t_reset();
    rst_n_i = 1'b0;
    #1;
    `CHK("ready in reset", 1'b0, issue_ready_o)
    `CHK("wb in reset", 1'b0, wb_valid_o)
    @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    #1;
    `CHK("ready after release", 1'b0, issue_ready_o)
    issue(imd_pkg::IMD_OP_ADD, 6, 1, 0, 1, 16'h0000, 0);
    settle(6);
    `CHK("cleared register", 64'h0, wb_val[6])
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    t_alu();
    t_mem();
    t_mdu();
    t_direct();
    t_reset();
    stop_test();
  end
endmodule // tb
